// ### design/pbc_defs.svh
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// ****************************************
// Widths and sizes
// ****************************************
`define PBC_PTR_W 13
`define PBC_MEM_DEPTH 8192
`define PBC_ADDR_W 5
`define PBC_PTR_HI_W 5

// ****************************************
// Register indexes
// ****************************************
`define PBC_A_CTRL1 5'h00
`define PBC_A_CTRL2 5'h01
`define PBC_A_RDPT_L 5'h02
`define PBC_A_RDPT_H 5'h03
`define PBC_A_WRPT_L 5'h04
`define PBC_A_WRPT_H 5'h05
`define PBC_A_DATA 5'h06
`define PBC_A_RXST_L 5'h07
`define PBC_A_RXST_H 5'h08
`define PBC_A_RXND_L 5'h09
`define PBC_A_RXND_H 5'h0a
`define PBC_A_RXWP_L 5'h0b
`define PBC_A_RXWP_H 5'h0c
`define PBC_A_RXRD_L 5'h0d
`define PBC_A_RXRD_H 5'h0e
`define PBC_A_TXST_L 5'h0f
`define PBC_A_TXST_H 5'h10
`define PBC_A_TXND_L 5'h11
`define PBC_A_TXND_H 5'h12
`define PBC_A_PKTCNT 5'h13

// ****************************************
// Control bit positions
// ****************************************
`define PBC_B_TX_RESET 7
`define PBC_B_RX_RESET 6
`define PBC_B_DMA_BUSY 5
`define PBC_B_DMA_CSUM 4
`define PBC_B_TX_REQ 3
`define PBC_B_RX_EN 2
`define PBC_B_AUTO_ADV 7
`define PBC_B_PKT_DEC 6
`define PBC_B_PWR_SAVE 5
`define PBC_B_RESV 4
`define PBC_B_VREG_LOW 3

// ****************************************
// Reset values
// ****************************************
`define PBC_PTR_RST 13'h0000
`define PBC_CNT_RST 8'h00
`define PBC_CNT_MAX 8'hff
`define PBC_BYTE_ZERO 8'h00
`define PBC_AUTO_ADV_RST 1'b1

`endif

// ### design/pbc_pkg.sv
package pbc_pkg;

    // Kind of word handed from the link domain
    typedef enum logic [1:0] {
        PBC_K_NONE = 2'h0,
        PBC_K_DATA = 2'h1,
        PBC_K_BAD = 2'h2,
        PBC_K_GOOD = 2'h3
    } pbc_kind_t;

    // Receive frame state, Gray along idle, store, drop
    typedef enum logic [1:0] {
        PBC_RX_IDLE = 2'b00,
        PBC_RX_STORE = 2'b01,
        PBC_RX_DROP = 2'b11
    } pbc_rx_state_t;

endpackage : pbc_pkg

// ### design/pbc_top.sv
`timescale 1ns/1ps
`include "pbc_defs.svh"
// Summary of operation
// - Transmit reset bit holds transmit logic in reset while set.
// - Receive reset bit holds all receive logic in reset while set.
// - DMA start bit launches an operation and reads one until DMA idles.
// - DMA mode bit picks checksum when set, copy when clear.
// - Transmit request starts a send and reads one until transmit idles.
// - Receive enable stores passing packets; clear means all packets ignored.
// - Two-bit bank selector picks register bank zero to three.
// - Auto-advance moves buffer pointers on each data window access; resets to one.
// - Writing one to decrement lowers packet count by one, bit self-clears.
// - Power save bit puts MAC, PHY and control into sleep.
// - Regulator low-current bit only counts while power save is set.
// - Reserved bit four kept zero by host; low three bits read zero.
// - Packet memory is 8 Kbytes shared by receive and transmit regions.
// - Receive FIFO includes both its start and end byte.
// - After end byte, next received byte goes to start; never outside.
// - FIFO may wrap across top of memory and still works.
// - Hardware write pointer is read-only, updated per good packet.
// - Receive writes stop short of the host read pointer.
// - Full FIFO discards new data and keeps old data.
// - No overlap check on transmit pointers; host avoids overlap.
// - Sequential reads wrap FIFO end to start, writes wrap only at top of memory.
module pbc_top (
    // System
    input wire logic SYS_CLK_IN,
    input wire logic RST_B_IN,
    // Register port from the command decoder
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [`PBC_ADDR_W-1:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    output logic [7:0] REG_RDATA_OUT,
    // Receive link, on its own clock
    input wire logic LINK_CLK_IN,
    input wire logic RX_VALID_IN,
    input wire logic [7:0] RX_DATA_IN,
    input wire logic RX_END_IN,
    input wire logic RX_GOOD_IN,
    // Engines outside this block
    input wire logic TX_DONE_IN,
    input wire logic DMA_DONE_IN,
    output logic TX_RESET_OUT,
    output logic TX_REQUEST_OUT,
    output logic [`PBC_PTR_W-1:0] TX_START_OUT,
    output logic [`PBC_PTR_W-1:0] TX_END_OUT,
    output logic RX_RESET_OUT,
    output logic DMA_GO_OUT,
    output logic DMA_CHECKSUM_MODE_OUT,
    output logic [1:0] BANK_SEL_OUT,
    output logic POWER_SAVE_OUT,
    output logic REG_LOW_CURRENT_OUT
);

    // ****************************************
    // Control registers
    // ****************************************
    logic tx_reset, rx_reset, dma_busy, dma_csum, tx_req, rx_en;
    logic [1:0] bank;
    logic auto_adv, pwr_save, resv, vreg_low;
    logic [`PBC_PTR_W-1:0] rd_ptr, wr_ptr, rx_start, rx_end, rx_wp, rx_hw_wp, rx_rd_ptr;
    logic [`PBC_PTR_W-1:0] tx_start, tx_end;
    logic [7:0] pkt_cnt;
    logic [7:0] mem [0:`PBC_MEM_DEPTH-1];

    wire wr_c1 = REG_WR_IN && (REG_ADDR_IN == `PBC_A_CTRL1);
    wire wr_c2 = REG_WR_IN && (REG_ADDR_IN == `PBC_A_CTRL2);
    wire wr_win = REG_WR_IN && (REG_ADDR_IN == `PBC_A_DATA);
    wire rd_win = REG_RD_IN && (REG_ADDR_IN == `PBC_A_DATA);
    wire dma_set = wr_c1 && REG_WDATA_IN[`PBC_B_DMA_BUSY];
    wire next_tx_reset = wr_c1 ? REG_WDATA_IN[`PBC_B_TX_RESET] : tx_reset;
    wire tx_set = wr_c1 && REG_WDATA_IN[`PBC_B_TX_REQ];
    wire pkt_dec = wr_c2 && REG_WDATA_IN[`PBC_B_PKT_DEC];
    wire next_pwr_save = wr_c2 ? REG_WDATA_IN[`PBC_B_PWR_SAVE] : pwr_save;
    wire next_vreg_low = wr_c2 ? REG_WDATA_IN[`PBC_B_VREG_LOW] : vreg_low;
    // Set wins over the done pulse, reset wins over both
    wire next_tx_req = next_tx_reset ? 1'b0 : (tx_set || (tx_req && !TX_DONE_IN));

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            {tx_reset, rx_reset, dma_busy, dma_csum, tx_req, rx_en} <= 6'h00;
            bank <= 2'h0;
            auto_adv <= `PBC_AUTO_ADV_RST;
            {pwr_save, resv, vreg_low} <= 3'h0;
            DMA_GO_OUT <= 1'b0;
            REG_LOW_CURRENT_OUT <= 1'b0;
        end else begin
            if (wr_c1) begin
                rx_reset <= REG_WDATA_IN[`PBC_B_RX_RESET];
                dma_csum <= REG_WDATA_IN[`PBC_B_DMA_CSUM];
                rx_en <= REG_WDATA_IN[`PBC_B_RX_EN];
                bank <= REG_WDATA_IN[1:0];
            end
            if (wr_c2) begin
                auto_adv <= REG_WDATA_IN[`PBC_B_AUTO_ADV];
                resv <= REG_WDATA_IN[`PBC_B_RESV];
            end
            tx_reset <= next_tx_reset;
            tx_req <= next_tx_req;
            dma_busy <= dma_set || (dma_busy && !DMA_DONE_IN);
            DMA_GO_OUT <= dma_set && !dma_busy;
            pwr_save <= next_pwr_save;
            vreg_low <= next_vreg_low;
            REG_LOW_CURRENT_OUT <= next_pwr_save && next_vreg_low;
        end
    end

    assign TX_RESET_OUT = tx_reset;
    assign TX_REQUEST_OUT = tx_req;
    assign RX_RESET_OUT = rx_reset;
    assign DMA_CHECKSUM_MODE_OUT = dma_csum;
    assign BANK_SEL_OUT = bank;
    assign POWER_SAVE_OUT = pwr_save;
    assign TX_START_OUT = tx_start;
    assign TX_END_OUT = tx_end;

    // ****************************************
    // Link domain capture
    // ****************************************
    // Only the reset level crosses into the link side
    logic link_live, lrst_s1, lrst_s2;
    logic link_tog;
    pbc_pkg::pbc_kind_t link_kind;
    logic [7:0] link_data;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            link_live <= 1'b0;
        end else begin
            link_live <= !rx_reset;
        end
    end

    always_ff @(posedge LINK_CLK_IN) begin
        lrst_s1 <= link_live;
        lrst_s2 <= lrst_s1;
    end

    // Word held stable until the next one; spacing covers the sync delay
    always_ff @(posedge LINK_CLK_IN) begin
        if (!lrst_s2) begin
            link_tog <= 1'b0;
            link_kind <= pbc_pkg::PBC_K_NONE;
            link_data <= `PBC_BYTE_ZERO;
        end else if (RX_VALID_IN || RX_END_IN) begin
            link_tog <= !link_tog;
            link_data <= RX_DATA_IN;
            link_kind <= RX_END_IN ? (RX_GOOD_IN ? pbc_pkg::PBC_K_GOOD : pbc_pkg::PBC_K_BAD)
                                   : pbc_pkg::PBC_K_DATA;
        end
    end

    // ****************************************
    // Crossing into the system domain
    // ****************************************
    logic tog_s1, tog_s2, tog_s3;

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            {tog_s1, tog_s2, tog_s3} <= 3'h0;
        end else begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    wire word_evt = (tog_s2 != tog_s3) && !rx_reset;
    wire rx_is_data = word_evt && (link_kind == pbc_pkg::PBC_K_DATA);
    wire rx_is_end = word_evt && (link_kind != pbc_pkg::PBC_K_DATA);
    wire rx_is_good = word_evt && (link_kind == pbc_pkg::PBC_K_GOOD);

    // ****************************************
    // Receive FIFO engine
    // ****************************************
    pbc_pkg::pbc_rx_state_t rx_state, next_rx_state;
    logic pend, commit;
    logic [`PBC_PTR_W-1:0] pend_addr;
    logic [7:0] pend_data;

    // Natural 13-bit rollover carries a FIFO across the top of memory
    wire [`PBC_PTR_W-1:0] rx_wp_inc = (rx_wp == rx_end) ? rx_start : rx_wp + 1'b1;
    wire rx_full = (rx_wp_inc == rx_rd_ptr);
    wire frame_ok = (rx_state == pbc_pkg::PBC_RX_STORE) ||
                    ((rx_state == pbc_pkg::PBC_RX_IDLE) && rx_en);
    wire byte_store = rx_is_data && frame_ok && !rx_full;
    wire next_commit = rx_is_end && rx_is_good && (rx_state == pbc_pkg::PBC_RX_STORE) && rx_en;

    always_comb begin
        next_rx_state = rx_state;
        if (rx_is_end) begin
            next_rx_state = pbc_pkg::PBC_RX_IDLE;
        end else if (rx_is_data) begin
            next_rx_state = byte_store ? pbc_pkg::PBC_RX_STORE : pbc_pkg::PBC_RX_DROP;
        end
    end

    wire ptr_lo = REG_WR_IN;
    wire [`PBC_PTR_HI_W-1:0] wr_hi_val = REG_WDATA_IN[`PBC_PTR_HI_W-1:0];
    wire [`PBC_PTR_W-1:0] next_rx_start =
        (ptr_lo && REG_ADDR_IN == `PBC_A_RXST_L) ? {rx_start[12:8], REG_WDATA_IN} :
        (ptr_lo && REG_ADDR_IN == `PBC_A_RXST_H) ? {wr_hi_val, rx_start[7:0]} : rx_start;
    wire rx_start_wr = (next_rx_start != rx_start);

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            rx_state <= pbc_pkg::PBC_RX_IDLE;
            rx_wp <= `PBC_PTR_RST;
            rx_hw_wp <= `PBC_PTR_RST;
            commit <= 1'b0;
        end else if (rx_reset || rx_start_wr) begin
            rx_state <= pbc_pkg::PBC_RX_IDLE;
            rx_wp <= next_rx_start;
            rx_hw_wp <= next_rx_start;
            commit <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            commit <= next_commit;
            if (byte_store) begin
                rx_wp <= rx_wp_inc;
            end else if (rx_is_end && !next_commit) begin
                rx_wp <= rx_hw_wp;
            end
            if (next_commit) begin
                rx_hw_wp <= rx_wp;
            end
        end
    end

    // ****************************************
    // Host pointers and data window
    // ****************************************
    wire [`PBC_PTR_W-1:0] rd_ptr_inc = (rd_ptr == rx_end) ? rx_start : rd_ptr + 1'b1;
    wire [`PBC_PTR_W-1:0] wr_ptr_inc = wr_ptr + 1'b1;
    // Host write owns the single write port; a received byte waits one cycle
    wire mem_host_wr = wr_win;
    wire mem_rx_wr = pend && !wr_win;

    always_ff @(posedge SYS_CLK_IN) begin
        if (mem_host_wr) begin
            mem[wr_ptr] <= REG_WDATA_IN;
        end else if (mem_rx_wr) begin
            mem[pend_addr] <= pend_data;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            pend <= 1'b0;
            pend_addr <= `PBC_PTR_RST;
            pend_data <= `PBC_BYTE_ZERO;
        end else if (byte_store && !rx_reset && !rx_start_wr) begin
            pend <= 1'b1;
            pend_addr <= rx_wp;
            pend_data <= link_data;
        end else if (mem_rx_wr) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            {rd_ptr, wr_ptr, rx_end, rx_rd_ptr} <= {4{`PBC_PTR_RST}};
            {rx_start, tx_start, tx_end} <= {3{`PBC_PTR_RST}};
        end else begin
            rx_start <= next_rx_start;
            if (rd_win && auto_adv) begin
                rd_ptr <= rd_ptr_inc;
            end
            if (wr_win && auto_adv) begin
                wr_ptr <= wr_ptr_inc;
            end
            if (REG_WR_IN) begin
                unique case (REG_ADDR_IN)
                    `PBC_A_RDPT_L: rd_ptr[7:0] <= REG_WDATA_IN;
                    `PBC_A_RDPT_H: rd_ptr[12:8] <= wr_hi_val;
                    `PBC_A_WRPT_L: wr_ptr[7:0] <= REG_WDATA_IN;
                    `PBC_A_WRPT_H: wr_ptr[12:8] <= wr_hi_val;
                    `PBC_A_RXND_L: rx_end[7:0] <= REG_WDATA_IN;
                    `PBC_A_RXND_H: rx_end[12:8] <= wr_hi_val;
                    `PBC_A_RXRD_L: rx_rd_ptr[7:0] <= REG_WDATA_IN;
                    `PBC_A_RXRD_H: rx_rd_ptr[12:8] <= wr_hi_val;
                    `PBC_A_TXST_L: tx_start[7:0] <= REG_WDATA_IN;
                    `PBC_A_TXST_H: tx_start[12:8] <= wr_hi_val;
                    `PBC_A_TXND_L: tx_end[7:0] <= REG_WDATA_IN;
                    `PBC_A_TXND_H: tx_end[12:8] <= wr_hi_val;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // Pending packet counter
    // ****************************************
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN || rx_reset) begin
            pkt_cnt <= `PBC_CNT_RST;
        end else if (commit && !pkt_dec && pkt_cnt != `PBC_CNT_MAX) begin
            pkt_cnt <= pkt_cnt + 1'b1;
        end else if (pkt_dec && !commit && pkt_cnt != `PBC_CNT_RST) begin
            pkt_cnt <= pkt_cnt - 1'b1;
        end
    end

    // ****************************************
    // Register read path
    // ****************************************
    logic [7:0] rd_mux;
    wire [7:0] c1_val = {tx_reset, rx_reset, dma_busy, dma_csum, tx_req, rx_en, bank};
    // Decrement bit always reads zero, low bits are unimplemented
    wire [7:0] c2_val = {auto_adv, 1'b0, pwr_save, resv, vreg_low, 3'h0};

    always_comb begin
        unique case (REG_ADDR_IN)
            `PBC_A_CTRL1: rd_mux = c1_val;
            `PBC_A_CTRL2: rd_mux = c2_val;
            `PBC_A_RDPT_L: rd_mux = rd_ptr[7:0];
            `PBC_A_RDPT_H: rd_mux = {3'h0, rd_ptr[12:8]};
            `PBC_A_WRPT_L: rd_mux = wr_ptr[7:0];
            `PBC_A_WRPT_H: rd_mux = {3'h0, wr_ptr[12:8]};
            `PBC_A_DATA: rd_mux = mem[rd_ptr];
            `PBC_A_RXST_L: rd_mux = rx_start[7:0];
            `PBC_A_RXST_H: rd_mux = {3'h0, rx_start[12:8]};
            `PBC_A_RXND_L: rd_mux = rx_end[7:0];
            `PBC_A_RXND_H: rd_mux = {3'h0, rx_end[12:8]};
            `PBC_A_RXWP_L: rd_mux = rx_hw_wp[7:0];
            `PBC_A_RXWP_H: rd_mux = {3'h0, rx_hw_wp[12:8]};
            `PBC_A_RXRD_L: rd_mux = rx_rd_ptr[7:0];
            `PBC_A_RXRD_H: rd_mux = {3'h0, rx_rd_ptr[12:8]};
            `PBC_A_TXST_L: rd_mux = tx_start[7:0];
            `PBC_A_TXST_H: rd_mux = {3'h0, tx_start[12:8]};
            `PBC_A_TXND_L: rd_mux = tx_end[7:0];
            `PBC_A_TXND_H: rd_mux = {3'h0, tx_end[12:8]};
            `PBC_A_PKTCNT: rd_mux = pkt_cnt;
            default: rd_mux = `PBC_BYTE_ZERO;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            REG_RDATA_OUT <= `PBC_BYTE_ZERO;
        end else if (REG_RD_IN) begin
            REG_RDATA_OUT <= rd_mux;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    property p_tx_reset;
        wr_c1 && REG_WDATA_IN[`PBC_B_TX_RESET] |=> TX_RESET_OUT && !TX_REQUEST_OUT;
    endproperty
    a_tx_reset: assert property (p_tx_reset) else $error("tx reset not held");
    property p_rx_reset;
        wr_c1 && REG_WDATA_IN[`PBC_B_RX_RESET] |=> RX_RESET_OUT ##1 (rx_wp == rx_start);
    endproperty
    a_rx_reset: assert property (p_rx_reset) else $error("rx reset not applied");
    property p_dma_go;
        dma_set && !dma_busy |=> DMA_GO_OUT && dma_busy ##1 !DMA_GO_OUT;
    endproperty
    a_dma_go: assert property (p_dma_go) else $error("dma start wrong");
    property p_dma_mode;
        DMA_GO_OUT |-> DMA_CHECKSUM_MODE_OUT == $past(REG_WDATA_IN[`PBC_B_DMA_CSUM]);
    endproperty
    a_dma_mode: assert property (p_dma_mode) else $error("dma mode wrong");
    property p_tx_hold;
        tx_req && !TX_DONE_IN && !wr_c1 |=> tx_req;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx request dropped");
    property p_rx_ignore;
        rx_is_data && rx_state == pbc_pkg::PBC_RX_IDLE && !rx_en && !rx_start_wr |=>
            rx_state == pbc_pkg::PBC_RX_DROP && $stable(rx_wp);
    endproperty
    a_rx_ignore: assert property (p_rx_ignore) else $error("byte stored while disabled");
    property p_auto_adv;
        rd_win && !REG_WR_IN |=> rd_ptr == ($past(auto_adv) ? $past(rd_ptr_inc) : $past(rd_ptr));
    endproperty
    a_auto_adv: assert property (p_auto_adv) else $error("read pointer step wrong");
    property p_pkt_dec;
        pkt_dec && !commit && pkt_cnt != `PBC_CNT_RST && !rx_reset |=> pkt_cnt == $past(pkt_cnt) - 1;
    endproperty
    a_pkt_dec: assert property (p_pkt_dec) else $error("count not decremented");
    property p_low_current;
        REG_LOW_CURRENT_OUT |-> pwr_save && vreg_low;
    endproperty
    a_low_current: assert property (p_low_current) else $error("low current without save");
    property p_c2_read;
        REG_RD_IN && REG_ADDR_IN == `PBC_A_CTRL2 |=> REG_RDATA_OUT[2:0] == 3'h0;
    endproperty
    a_c2_read: assert property (p_c2_read) else $error("ctrl2 low bits not zero");
    property p_wrap;
        byte_store && rx_wp == rx_end && !rx_start_wr |=> rx_wp == rx_start;
    endproperty
    a_wrap: assert property (p_wrap) else $error("fifo did not wrap");
    property p_full;
        rx_is_data && rx_full && !rx_start_wr |=>
            rx_state == pbc_pkg::PBC_RX_DROP && $stable(rx_wp);
    endproperty
    a_full: assert property (p_full) else $error("stored into full fifo");

    c_commit: cover property (commit);
    c_full_drop: cover property (rx_is_data && rx_full && frame_ok);
    c_wrap: cover property (byte_store && rx_wp == rx_end);

endmodule : pbc_top

// ### dv/pbc_link_model.sv
`timescale 1ns/1ps
module pbc_link_model (
    // Link clock
    input wire logic link_clk_in,
    // Receive words
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_end_out,
    output logic rx_good_out
);
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h00;
        rx_end_out = 1'b0;
        rx_good_out = 1'b0;
    end
    // Wide gap of four link cycles; the crossing needs at most three system cycles
    task automatic word(input logic v, input logic e, input logic [7:0] d);
        @(posedge link_clk_in);
        #1;
        rx_valid_out = v;
        rx_end_out = e;
        rx_data_out = d;
        @(posedge link_clk_in);
        #1;
        rx_valid_out = 1'b0;
        rx_end_out = 1'b0;
        rx_data_out = ~d;
        rx_good_out = ~rx_good_out;
        repeat (4) @(posedge link_clk_in);
    endtask : word
    task automatic send(input logic [7:0] b [3], input int n, input logic good);
        for (int i = 0; i < n; i++) begin
            word(1'b1, 1'b0, b[i]);
        end
        rx_good_out = good;
        word(1'b0, 1'b1, 8'h00);
    endtask : send
endmodule : pbc_link_model

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "pbc_defs.svh"
module testbench;
    // ****
    // Stimulus and hookup
    // ****
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic tx_done = 1'b0;
    logic dma_done = 1'b0;
    logic [7:0] rdata;
    logic rx_valid, rx_end, rx_good, tx_rst, tx_req, rx_rst, dma_go, csum, psave, lowc;
    logic [7:0] rx_data;
    logic [1:0] bank;
    logic [12:0] tx_st, tx_nd;
    logic [7:0] fr [3];
    logic [7:0] v;
    logic [12:0] p;
    int n_errors = 0;
    int checks_done = 0;
    always #5 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end
    pbc_top pbc_top_inst (.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b), .REG_WR_IN(wr),
        .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .LINK_CLK_IN(link_clk), .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data),
        .RX_END_IN(rx_end), .RX_GOOD_IN(rx_good), .TX_DONE_IN(tx_done),
        .DMA_DONE_IN(dma_done), .TX_RESET_OUT(tx_rst), .TX_REQUEST_OUT(tx_req),
        .TX_START_OUT(tx_st), .TX_END_OUT(tx_nd), .RX_RESET_OUT(rx_rst),
        .DMA_GO_OUT(dma_go), .DMA_CHECKSUM_MODE_OUT(csum), .BANK_SEL_OUT(bank),
        .POWER_SAVE_OUT(psave), .REG_LOW_CURRENT_OUT(lowc));
    pbc_link_model pbc_link_model_inst (.link_clk_in(link_clk), .rx_valid_out(rx_valid),
        .rx_data_out(rx_data), .rx_end_out(rx_end), .rx_good_out(rx_good));
    // ****
    // Helpers
    // ****
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        rd = 1'b1;
        addr = a;
        @(negedge sys_clk);
        rd = 1'b0;
        d = rdata;
    endtask : reg_rd
    task automatic rchk(input string what, input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        reg_rd(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask : rchk
    task automatic wr16(input logic [4:0] a, input logic [12:0] p);
        reg_wr(a, p[7:0]);
        reg_wr(a + 5'h01, {3'h0, p[12:8]});
    endtask : wr16
    task automatic rd16(input string what, input logic [4:0] a, input logic [12:0] exp);
        rchk(what, a, exp[7:0]);
        rchk(what, a + 5'h01, {3'h0, exp[12:8]});
    endtask : rd16
    task automatic pulse(input bit dma);
        @(negedge sys_clk);
        if (dma) dma_done = 1'b1; else tx_done = 1'b1;
        @(negedge sys_clk);
        dma_done = 1'b0;
        tx_done = 1'b0;
    endtask : pulse
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
    // ****
    // Tests
    // ****
    initial begin
        v = 8'($urandom(32'h8851));
        // Held past four link edges so the link side resets too
        repeat (13) @(negedge sys_clk);
        rst_b = 1'b1;
        rchk("ctrl1", `PBC_A_CTRL1, 8'h00);
        rchk("ctrl2", `PBC_A_CTRL2, 8'h80);
        rchk("unmapped", 5'h1f, 8'h00);
        $display("reset values done");
        for (int b = 0; b < 4; b++) begin
            v = {2'($urandom), 4'h0, 2'(b)};
            reg_wr(`PBC_A_CTRL1, v);
            check("transmit_logic_reset", tx_rst, v[7]);
            check("receive_logic_reset", rx_rst, v[6]);
            check("bank", bank, v[1:0]);
        end
        reg_wr(`PBC_A_CTRL1, 8'h38);
        check("dmago", dma_go, 1'b1);
        check("csum", csum, 1'b1);
        reg_wr(`PBC_A_CTRL1, 8'h00);
        rchk("busy", `PBC_A_CTRL1, 8'h28);
        check("txreq", tx_req, 1'b1);
        pulse(1'b1);
        pulse(1'b0);
        rchk("idle", `PBC_A_CTRL1, 8'h00);
        $display("control bits done");
        for (int k = 0; k < 4; k++) begin
            v = {2'b00, k[0], 1'b0, k[1], 3'h7};
            reg_wr(`PBC_A_CTRL2, v);
            check("lowcur", lowc, k[0] & k[1]);
            check("psave", psave, k[0]);
            rchk("ctrl2rb", `PBC_A_CTRL2, v & 8'hf8);
        end
        p = 13'($urandom);
        wr16(`PBC_A_TXST_L, p);
        check("txst", tx_st, p);
        wr16(`PBC_A_TXND_L, ~p);
        check("txnd", tx_nd, {3'h0, ~p});
        $display("power bits done");
        reg_wr(`PBC_A_CTRL1, 8'h00);
        wr16(`PBC_A_RXST_L, 13'h1ffe);
        wr16(`PBC_A_RXND_L, 13'h0001);
        wr16(`PBC_A_RXRD_L, 13'h1ffe);
        reg_wr(`PBC_A_CTRL2, 8'h80);
        reg_wr(`PBC_A_CTRL1, 8'h04);
        for (int i = 0; i < 3; i++) fr[i] = 8'($urandom);
        pbc_link_model_inst.send(fr, 3, 1'b1);
        repeat (30) @(negedge sys_clk);
        rd16("hwwp", `PBC_A_RXWP_L, 13'h0001);
        rchk("count", `PBC_A_PKTCNT, 8'h01);
        // No spare byte left, so the frame is thrown away
        pbc_link_model_inst.send(fr, 2, 1'b1);
        repeat (30) @(negedge sys_clk);
        rd16("fullwp", `PBC_A_RXWP_L, 13'h0001);
        rchk("fullcnt", `PBC_A_PKTCNT, 8'h01);
        wr16(`PBC_A_RDPT_L, 13'h1ffe);
        for (int i = 0; i < 3; i++) rchk("data", `PBC_A_DATA, fr[i]);
        rd16("rdpt", `PBC_A_RDPT_L, 13'h0001);
        reg_rd(`PBC_A_DATA, v);
        rd16("rdwrap", `PBC_A_RDPT_L, 13'h1ffe);
        wr16(`PBC_A_RXRD_L, 13'h0001);
        // Next frame starts on the end byte and must wrap to the start
        pbc_link_model_inst.send(fr, 2, 1'b1);
        repeat (30) @(negedge sys_clk);
        rd16("wrapwp", `PBC_A_RXWP_L, 13'h1fff);
        rchk("count2", `PBC_A_PKTCNT, 8'h02);
        $display("receive fifo done");
        reg_wr(`PBC_A_CTRL1, 8'h00);
        pbc_link_model_inst.send(fr, 1, 1'b1);
        repeat (30) @(negedge sys_clk);
        rchk("offcnt", `PBC_A_PKTCNT, 8'h02);
        reg_wr(`PBC_A_CTRL2, 8'h40);
        rchk("deccnt", `PBC_A_PKTCNT, 8'h01);
        rchk("decclr", `PBC_A_CTRL2, 8'h00);
        rchk("wrapdata", `PBC_A_DATA, fr[1]);
        rd16("noadv", `PBC_A_RDPT_L, 13'h1ffe);
        $display("decrement done");
        reg_wr(`PBC_A_CTRL2, 8'h80);
        wr16(`PBC_A_WRPT_L, 13'h1fff);
        v = 8'($urandom);
        reg_wr(`PBC_A_DATA, v);
        reg_wr(`PBC_A_DATA, ~v);
        rd16("wrpt", `PBC_A_WRPT_L, 13'h0001);
        wr16(`PBC_A_RDPT_L, 13'h1fff);
        rchk("wrdata", `PBC_A_DATA, v);
        rchk("wrdata2", `PBC_A_DATA, ~v);
        $display("buffer write done");
        wrap_up();
    end
endmodule : testbench
